//--- hdl/bcc_pkg.sv
package bcc_pkg;
  // bus clock and cold reset length
  localparam int CLK_MHZ         = 100;
  localparam int COLD_RST_US     = 1000;
  localparam int COLD_RST_CYCLES = COLD_RST_US * CLK_MHZ;
  // register byte offsets
  localparam logic [7:0] OFS_DBG_CTRL = 8'h00;
  localparam logic [7:0] OFS_CR_FOUR  = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_MC_ADDR  = 8'h14;
  localparam logic [7:0] OFS_MC_CTRL  = 8'h18;
  localparam logic [7:0] OFS_DMR0     = 8'h20;
  localparam logic [7:0] OFS_DMR3     = 8'h2C;
  // debug control fields: pin selects low, breakpoint enables above
  localparam int DBG_SEL_LO = 0;
  localparam int DBG_SEL_HI = 1;
  localparam int DBG_EN_LSB = 4;
  localparam logic [31:0] DBG_CTRL_RST = 32'h0000_0000;
  // machine check enable position in control register four
  localparam int MCE_BIT = 6;
  // interrupt status bits
  localparam int IRQ_BACKOFF = 0;
  localparam int IRQ_BUS_CHECK_N  = 1;
  localparam int IRQ_BP_HIT  = 2;
  localparam int IRQ_MC_DROP = 3;
  localparam int IRQ_W       = 4;
  // ratio lookup: core multiplier per select code, values arbitrary
  localparam logic [15:0] RATIO_LUT = 16'h3542;
  // bus cycle states
  typedef enum logic [1:0] {ST_IDLE, ST_T1, ST_T2, ST_HOLD} bcc_state_type;
endpackage

//--- hdl/bcc_top.sv
`timescale 1ns/1ns
module bcc_top #(
  parameter int COLD_RST_CYCLES = bcc_pkg::COLD_RST_CYCLES
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             irq_out,
  // internal bus request from the core
  input  wire logic        req_valid_in,
  input  wire logic [31:3] req_addr_in,
  input  wire logic        req_write_in,
  input  wire logic [3:0]  req_ctrl_in,
  output logic             req_ready_out,
  output logic             req_done_out,
  // internal snoop and perf events
  input  wire logic        snoop_valid_in,
  input  wire logic [31:5] snoop_line_in,
  input  wire logic [1:0]  perf_event_in,
  // external pins
  input  wire logic [1:0]  bus_ratio_select_in,
  input  wire logic        bus_backoff_n_in,
  input  wire logic        burst_ready_n_in,
  input  wire logic        burst_ready_copy_n_in,
  input  wire logic        bus_check_n_in,
  input  wire logic        stop_clock_request_n_in,
  output logic             bus_request_out,
  output logic             ads_n_out,
  output logic [31:3]      addr_out,
  output logic             write_out,
  output logic             bus_oe_out,
  output logic [3:0]       breakpoint_match_pins_out,
  output logic             machine_check_exc_out,
  output logic [3:0]       core_ratio_out
);

  // ratio code to core multiplier
  function automatic logic [3:0] ratio_of(input logic [1:0] code);
    ratio_of = bcc_pkg::RATIO_LUT[{code, 2'h0} +: 4];
  endfunction

  // two-stage synchronisers for pins
  logic [6:0] sync1;
  logic [6:0] sync2;
  always_ff @(posedge clk_in) begin
    sync1 <= {bus_ratio_select_in, bus_backoff_n_in, burst_ready_n_in,
              burst_ready_copy_n_in, bus_check_n_in, stop_clock_request_n_in};
    sync2 <= sync1;
  end
  logic [1:0] ratio_s;
  logic       bus_backoff_n;
  logic       rdy;
  logic       bchk;
  logic       stop_clock_request_n;
  assign ratio_s = sync2[6:5];
  assign bus_backoff_n    = ~sync2[4];
  assign rdy     = ~sync2[3] | ~sync2[2];
  assign bchk    = ~sync2[1];
  assign stop_clock_request_n  = ~sync2[0];

  // cold reset length and ratio capture, untouched by warm reset
  logic [31:0] rst_cnt = 32'h0000_0000; // power-up value, no reset may clear it
  logic [1:0]  ratio_q;
  logic        rst_d;
  logic [31:0] next_rst_cnt;
  logic [1:0]  next_ratio_q;
  always_comb begin
    next_rst_cnt = srst_in ? rst_cnt : 32'h0000_0000;
    if (srst_in && rst_cnt < 32'(COLD_RST_CYCLES))
      next_rst_cnt = rst_cnt + 32'h0000_0001;
    next_ratio_q = ratio_q;
    if (rst_d && !srst_in && rst_cnt >= 32'(COLD_RST_CYCLES))
      next_ratio_q = ratio_s;
  end
  always_ff @(posedge clk_in) begin
    rst_cnt <= next_rst_cnt;
    rst_d   <= srst_in;
    ratio_q <= next_ratio_q;
  end

  // apb access and register state
  logic               acc;
  logic               rd_stat;
  logic [31:0]        dbg_ctrl;
  logic [31:0]        cr_four;
  logic [31:0]        dmr [4];
  logic [bcc_pkg::IRQ_W-1:0] int_stat;
  logic [bcc_pkg::IRQ_W-1:0] int_mask;
  logic [bcc_pkg::IRQ_W-1:0] int_set;
  logic [31:3]        mc_addr;
  logic [5:0]         mc_ctrl;
  logic               mc_pend;
  assign acc     = psel_in & penable_in & pready_out;
  assign rd_stat = acc & ~pwrite_in & (paddr_in == bcc_pkg::OFS_INT_STAT);

  // local names for the bus cycle states
  localparam bcc_pkg::bcc_state_type ST_IDLE = bcc_pkg::ST_IDLE;
  localparam bcc_pkg::bcc_state_type ST_T1   = bcc_pkg::ST_T1;
  localparam bcc_pkg::bcc_state_type ST_T2   = bcc_pkg::ST_T2;
  localparam bcc_pkg::bcc_state_type ST_HOLD = bcc_pkg::ST_HOLD;

  // bus cycle state
  bcc_pkg::bcc_state_type state;
  bcc_pkg::bcc_state_type next_state;
  logic        cyc_valid;
  logic [31:3] cyc_addr;
  logic        cyc_write;
  logic [3:0]  cyc_ctrl;
  logic        next_cyc_valid;
  logic [31:3] next_cyc_addr;
  logic        next_cyc_write;
  logic [3:0]  next_cyc_ctrl;
  logic        next_done;
  logic        take;
  assign take = req_valid_in & req_ready_out;

  // bus cycle sequencing
  always_comb begin
    next_state     = state;
    next_cyc_valid = cyc_valid;
    next_cyc_addr  = cyc_addr;
    next_cyc_write = cyc_write;
    next_cyc_ctrl  = cyc_ctrl;
    next_done      = 1'b0;
    if (take) begin
      next_cyc_valid = 1'b1;
      next_cyc_addr  = req_addr_in;
      next_cyc_write = req_write_in;
      next_cyc_ctrl  = req_ctrl_in;
    end
    unique case (state)
      ST_IDLE: begin
        if (bus_backoff_n)
          next_state = ST_HOLD;
        else if (cyc_valid)
          next_state = ST_T1;
      end
      ST_T1: begin
        next_state = bus_backoff_n ? ST_HOLD : ST_T2;
      end
      ST_T2: begin
        if (bus_backoff_n) begin
          next_state = ST_HOLD;
        end else if (rdy) begin
          next_state     = ST_IDLE;
          next_cyc_valid = 1'b0;
          next_done      = 1'b1;
        end
      end
      ST_HOLD: begin
        // aborted cycle stays valid and returns to ST_IDLE, then restarts at T1
        if (!bus_backoff_n)
          next_state = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state     <= ST_IDLE;
      cyc_valid <= 1'b0;
      cyc_addr  <= '0;
      cyc_write <= 1'b0;
      cyc_ctrl  <= 4'h0;
    end else begin
      state     <= next_state;
      cyc_valid <= next_cyc_valid;
      cyc_addr  <= next_cyc_addr;
      cyc_write <= next_cyc_write;
      cyc_ctrl  <= next_cyc_ctrl;
    end
  end

  // registered pin drive and breakpoint compare
  logic [3:0] bp_hit;
  logic [3:0] next_bp_hit;
  logic [3:0] next_bp_pins;
  always_comb begin
    for (int i = 0; i < 4; i++)
      next_bp_hit[i] = (next_state == ST_T1) && (state != ST_T1)
        && dbg_ctrl[bcc_pkg::DBG_EN_LSB + i]
        && (dmr[i][31:3] == cyc_addr);
    next_bp_pins = next_bp_hit;
    if (!dbg_ctrl[bcc_pkg::DBG_SEL_LO])
      next_bp_pins[0] = perf_event_in[0];
    if (!dbg_ctrl[bcc_pkg::DBG_SEL_HI])
      next_bp_pins[1] = perf_event_in[1];
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bus_oe_out                <= 1'b0;
      ads_n_out                 <= 1'b1;
      addr_out                  <= '0;
      write_out                 <= 1'b0;
      req_ready_out             <= 1'b0;
      req_done_out              <= 1'b0;
      bus_request_out           <= 1'b0;
      bp_hit                    <= 4'h0;
      breakpoint_match_pins_out <= 4'h0;
      core_ratio_out            <= 4'h0;
    end else begin
      // floats in the clock after backoff is seen
      bus_oe_out <= (next_state == ST_T1) || (next_state == ST_T2);
      ads_n_out  <= next_state != ST_T1;
      addr_out   <= next_cyc_addr;
      write_out  <= next_cyc_write;
      req_ready_out   <= ~next_cyc_valid;
      req_done_out    <= next_done;
      bus_request_out <= next_cyc_valid | req_valid_in;
      bp_hit          <= next_bp_hit;
      breakpoint_match_pins_out <= next_bp_pins;
      core_ratio_out  <= ratio_of(ratio_q);
    end
  end

  // bus check capture and machine check sequencing
  logic        bchk_ev;
  logic        machine_check_enable;
  logic        drop;
  logic [31:3] next_mc_addr;
  logic [5:0]  next_mc_ctrl;
  logic        next_mc_pend;
  logic        next_exc;
  assign bchk_ev = bchk & ((state == ST_T2) | snoop_valid_in);
  assign machine_check_enable     = cr_four[bcc_pkg::MCE_BIT];
  assign drop    = mc_pend & stop_clock_request_n & snoop_valid_in & ~bchk_ev
                 & (snoop_line_in == mc_addr[31:5]);
  always_comb begin
    next_mc_addr = mc_addr;
    next_mc_ctrl = mc_ctrl;
    next_mc_pend = mc_pend;
    next_exc     = 1'b0;
    if (mc_pend && !stop_clock_request_n) begin
      next_mc_pend = 1'b0;
      next_exc     = 1'b1;
    end else if (drop) begin
      next_mc_pend = 1'b0;
    end
    if (bchk_ev) begin
      next_mc_addr = (state == ST_T2) ? cyc_addr : {snoop_line_in, 2'h0};
      next_mc_ctrl = {state != ST_T2, cyc_write, cyc_ctrl};
      if (machine_check_enable && stop_clock_request_n)
        next_mc_pend = 1'b1;
      else if (machine_check_enable)
        next_exc = 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mc_addr               <= '0;
      mc_ctrl               <= 6'h00;
      mc_pend               <= 1'b0;
      machine_check_exc_out <= 1'b0;
    end else begin
      mc_addr               <= next_mc_addr;
      mc_ctrl               <= next_mc_ctrl;
      mc_pend               <= next_mc_pend;
      machine_check_exc_out <= next_exc;
    end
  end

  // register file, read data and interrupt
  logic [31:0] next_dbg_ctrl;
  logic [31:0] next_cr_four;
  logic [31:0] next_dmr [4];
  logic [bcc_pkg::IRQ_W-1:0] next_int_stat;
  logic [bcc_pkg::IRQ_W-1:0] next_int_mask;
  logic [31:0] next_prdata;
  logic        next_err;
  logic        hit;
  always_comb begin
    next_dbg_ctrl = dbg_ctrl;
    next_cr_four  = cr_four;
    next_int_mask = int_mask;
    for (int i = 0; i < 4; i++)
      next_dmr[i] = dmr[i];
    int_set = '0;
    int_set[bcc_pkg::IRQ_BACKOFF] = (state != ST_HOLD) && (next_state == ST_HOLD);
    int_set[bcc_pkg::IRQ_BUS_CHECK_N]  = bchk_ev;
    int_set[bcc_pkg::IRQ_BP_HIT]  = |bp_hit;
    int_set[bcc_pkg::IRQ_MC_DROP] = drop;
    // set wins over the read clear
    next_int_stat = (int_stat & ~{bcc_pkg::IRQ_W{rd_stat}}) | int_set;
    if (acc && pwrite_in) begin
      unique case (paddr_in)
        bcc_pkg::OFS_DBG_CTRL: next_dbg_ctrl = pwdata_in;
        bcc_pkg::OFS_CR_FOUR:  next_cr_four  = pwdata_in;
        bcc_pkg::OFS_INT_MASK: next_int_mask = pwdata_in[bcc_pkg::IRQ_W-1:0];
        default: begin
          if (paddr_in >= bcc_pkg::OFS_DMR0 && paddr_in <= bcc_pkg::OFS_DMR3
              && paddr_in[1:0] == 2'h0)
            next_dmr[paddr_in[3:2]] = pwdata_in;
        end
      endcase
    end
    hit = 1'b1;
    next_prdata = 32'h0000_0000;
    unique case (paddr_in)
      bcc_pkg::OFS_DBG_CTRL: next_prdata = dbg_ctrl;
      bcc_pkg::OFS_CR_FOUR:  next_prdata = cr_four;
      bcc_pkg::OFS_STATUS:
        next_prdata = {28'h0000000, mc_pend, state == ST_HOLD, ratio_q};
      bcc_pkg::OFS_INT_STAT: next_prdata[bcc_pkg::IRQ_W-1:0] = int_stat;
      bcc_pkg::OFS_INT_MASK: next_prdata[bcc_pkg::IRQ_W-1:0] = int_mask;
      bcc_pkg::OFS_MC_ADDR:  next_prdata = {mc_addr, 3'h0};
      bcc_pkg::OFS_MC_CTRL:  next_prdata = {26'h0000000, mc_ctrl};
      default: begin
        if (paddr_in >= bcc_pkg::OFS_DMR0 && paddr_in <= bcc_pkg::OFS_DMR3
            && paddr_in[1:0] == 2'h0)
          next_prdata = dmr[paddr_in[3:2]];
        else
          hit = 1'b0;
      end
    endcase
    next_err = psel_in & ~penable_in & ~hit;
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dbg_ctrl    <= bcc_pkg::DBG_CTRL_RST;
      cr_four     <= 32'h0000_0000;
      int_stat    <= '0;
      int_mask    <= '0;
      for (int i = 0; i < 4; i++)
        dmr[i] <= 32'h0000_0000;
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      irq_out     <= 1'b0;
    end else begin
      dbg_ctrl    <= next_dbg_ctrl;
      cr_four     <= next_cr_four;
      int_stat    <= next_int_stat;
      int_mask    <= next_int_mask;
      for (int i = 0; i < 4; i++)
        dmr[i] <= next_dmr[i];
      prdata_out  <= next_prdata;
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= next_err;
      irq_out     <= |(next_int_stat & next_int_mask);
    end
  end

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_bus_backoff_n_seen;
    bus_backoff_n && (state == ST_T2 || state == ST_T1);
  endsequence
  sequence s_float;
    !bus_oe_out && state == ST_HOLD;
  endsequence
  AST_BUS_BACKOFF_N_FLOAT: assert property (s_bus_backoff_n_seen |=> s_float)
    else $error("pins not floated after backoff");
  AST_HOLD_KEEP: assert property (state == ST_HOLD && bus_backoff_n |=> state == ST_HOLD)
    else $error("left hold while backoff held");
  AST_REISSUE: assert property (state == ST_HOLD && !bus_backoff_n |=> ##1 !ads_n_out)
    else $error("aborted cycle not reissued");
  AST_RDY_WINDOW: assert property (req_done_out |-> $past(state) == ST_T2)
    else $error("ready taken outside data state");
  AST_RDY_COPY: assert property (state == ST_T2 && !bus_backoff_n && !sync2[2] |=> req_done_out)
    else $error("copy ready ignored");
  AST_BUS_REQUEST_OUT: assert property (cyc_valid |-> bus_request_out)
    else $error("bus request missing");
  AST_MC_EXC: assert property (bchk_ev && machine_check_enable && !stop_clock_request_n |=> machine_check_exc_out)
    else $error("machine check not taken");
  AST_MC_DEFER: assert property (mc_pend && stop_clock_request_n |=> !machine_check_exc_out)
    else $error("exception not deferred");
  AST_MC_REC: assert property (bchk_ev && state == ST_T2 |=> mc_addr == $past(cyc_addr))
    else $error("address not recorded");
  AST_PM_DEFAULT: assert property ($fell(srst_in) |-> !dbg_ctrl[0] && !dbg_ctrl[1])
    else $error("shared pins not perf monitor");
  AST_RATIO_HOLD: assert property (!$past(rst_d) |-> $stable(ratio_q))
    else $error("ratio changed outside reset");

endmodule // bcc_top

//--- tb/bcc_chipset_model.sv
`timescale 1ns/1ns
// chipset side: one burst ready pulse per bus cycle after a set delay
module bcc_chipset_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // device bus cycle pins
  input  wire logic       ads_n_in,
  input  wire logic       bus_oe_in,
  // answer control
  input  wire logic [3:0] delay_in,
  input  wire logic       use_copy_in,
  // ready lines, pulled up when idle
  output logic            burst_ready_n_out,
  output logic            burst_ready_copy_n_out
);
  logic       busy;
  logic [3:0] cnt;

  // cycle tracking, abandoned when the device floats the bus
  always_ff @(posedge clk_in) begin
    burst_ready_n_out      <= 1'b1;
    burst_ready_copy_n_out <= 1'b1;
    if (srst_in) begin
      busy <= 1'b0;
      cnt  <= 4'h0;
    end else if (!ads_n_in && bus_oe_in) begin
      busy <= 1'b1;
      cnt  <= delay_in;
    end else if (busy && !bus_oe_in) begin
      busy <= 1'b0;
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      // ready once data is valid or accepted
      if (use_copy_in) begin
        burst_ready_copy_n_out <= 1'b0;
      end else begin
        burst_ready_n_out <= 1'b0;
      end
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule // bcc_chipset_model

//--- tb/test_cpu_bus_cycle_control.sv
`timescale 1ns/1ns
module test_cpu_bus_cycle_control;
  logic        clk_in = 1'b0, srst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
  logic        pwrite_in = 1'b0, req_valid_in = 1'b0, req_write_in = 1'b0;
  logic        snoop_valid_in = 1'b0, bus_backoff_n_in = 1'b1, bus_check_n_in = 1'b1;
  logic        stop_clock_request_n_in = 1'b1, use_copy = 1'b0, err;
  logic        pready_out, pslverr_out, irq_out, req_ready_out, req_done_out;
  logic        bus_request_out, ads_n_out, write_out, bus_oe_out, machine_check_exc_out;
  logic        burst_ready_n_in, burst_ready_copy_n_in;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [31:3] req_addr_in = 29'h0, addr_out;
  logic [31:5] snoop_line_in = 27'h0;
  logic [3:0]  req_ctrl_in = 4'hA, delay = 4'h6, breakpoint_match_pins_out, core_ratio_out;
  logic [1:0]  perf_event_in = 2'h0, bus_ratio_select_in = 2'h2;
  int          n_errors = 0, checks = 0, ads_cnt = 0, exc_cnt = 0, bp_cnt = 0, n_wait;

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  bcc_top #(.COLD_RST_CYCLES(6)) u_dut (.clk_in, .srst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .irq_out,
    .req_valid_in, .req_addr_in, .req_write_in, .req_ctrl_in, .req_ready_out,
    .req_done_out, .snoop_valid_in, .snoop_line_in, .perf_event_in, .bus_ratio_select_in,
    .bus_backoff_n_in, .burst_ready_n_in, .burst_ready_copy_n_in, .bus_check_n_in,
    .stop_clock_request_n_in, .bus_request_out, .ads_n_out, .addr_out, .write_out,
    .bus_oe_out, .breakpoint_match_pins_out, .machine_check_exc_out, .core_ratio_out);

  bcc_chipset_model u_chipset (.clk_in, .srst_in, .ads_n_in(ads_n_out),
    .bus_oe_in(bus_oe_out), .delay_in(delay), .use_copy_in(use_copy),
    .burst_ready_n_out(burst_ready_n_in), .burst_ready_copy_n_out(burst_ready_copy_n_in));

  // pulse counters, sampled mid-cycle
  always @(negedge clk_in) begin
    if (ads_n_out === 1'b0) ads_cnt++;
    if (machine_check_exc_out === 1'b1) exc_cnt++;
    if (breakpoint_match_pins_out[0] === 1'b1) bp_cnt++;
  end

  task summarize;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task rst(input int n);
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (n) @(posedge clk_in);
    srst_in <= 1'b0;
  endtask

  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task req(input logic [31:3] a, input logic w);
    int n;
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_addr_in <= a;
    req_write_in <= w;
    n = 0;
    do begin @(posedge clk_in); n++; end while (req_ready_out !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    req_valid_in <= 1'b0;
    @(negedge clk_in);
    chk(bus_request_out, 1'b1);
  endtask

  task wait_ads;
    n_wait = 0;
    do begin @(negedge clk_in); n_wait++; end while (ads_n_out !== 1'b0 && n_wait < 100);
    if (n_wait >= 100) n_errors++;
  endtask

  task wait_done;
    n_wait = 0;
    do begin @(negedge clk_in); n_wait++; end while (req_done_out !== 1'b1 && n_wait < 100);
    if (n_wait >= 100) n_errors++;
  endtask

  // ratio capture, pin defaults, unmapped address, warm and cold reset
  task t_reset;
    cyc(3);
    chk(core_ratio_out, bcc_pkg::RATIO_LUT[8 +: 4]);
    apb(1'b0, bcc_pkg::OFS_STATUS, 32'h0);
    chk(rd[1:0], 2'h2);
    apb(1'b0, bcc_pkg::OFS_DBG_CTRL, 32'h0);
    chk(rd, bcc_pkg::DBG_CTRL_RST);
    @(posedge clk_in);
    perf_event_in <= 2'h2;
    cyc(3);
    chk(breakpoint_match_pins_out[1:0], 2'h2);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    @(posedge clk_in);
    perf_event_in <= 2'h0;
    bus_ratio_select_in <= 2'h1;
    cyc(4);
    rst(2);
    cyc(4);
    chk(core_ratio_out, bcc_pkg::RATIO_LUT[8 +: 4]);
    rst(8);
    cyc(4);
    chk(core_ratio_out, bcc_pkg::RATIO_LUT[4 +: 4]);
  endtask

  // a read on the primary ready line, a write on the copy line
  task t_cycles;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in);
      use_copy <= i[0];
      req(29'h100 + 29'(i), i[0]);
      wait_ads;
      chk(addr_out, 29'h100 + 29'(i));
      chk(write_out, i[0]);
      wait_done;
      chk(n_wait >= int'(delay) + 3, 1'b1);
    end
  endtask

  task t_backoff;
    int k;
    req(29'h200, 1'b0);
    wait_ads;
    @(posedge clk_in);
    bus_backoff_n_in <= 1'b0;
    cyc(4);
    chk(bus_oe_out, 1'b0);
    k = ads_cnt;
    cyc(10);
    chk(ads_cnt, k);
    chk(bus_request_out, 1'b1);
    chk(irq_out, 1'b0);
    @(posedge clk_in);
    bus_backoff_n_in <= 1'b1;
    wait_done;
    chk(ads_cnt, k + 1);
    chk(addr_out, 29'h200);
  endtask

  task t_bp;
    int k;
    apb(1'b1, bcc_pkg::OFS_DMR0, 32'h0000_4A40);
    apb(1'b1, bcc_pkg::OFS_DBG_CTRL, 32'h0000_0011);
    apb(1'b1, bcc_pkg::OFS_INT_MASK, 32'h0000_0004);
    @(posedge clk_in);
    perf_event_in <= 2'h3;
    k = bp_cnt;
    req(29'h948, 1'b0);
    wait_done;
    chk(bp_cnt, k + 1);
    chk(breakpoint_match_pins_out[1], 1'b1);
    chk(irq_out, 1'b1);
    apb(1'b0, bcc_pkg::OFS_INT_STAT, 32'h0);
    chk(rd[2], 1'b1);
    cyc(2);
    chk(irq_out, 1'b0);
    @(posedge clk_in);
    perf_event_in <= 2'h0;
  endtask

  task t_bus_check_n;
    int k;
    apb(1'b1, bcc_pkg::OFS_CR_FOUR, 32'h0000_0040);
    apb(1'b1, bcc_pkg::OFS_INT_MASK, 32'h0000_0002);
    k = exc_cnt;
    req(29'h333, 1'b1);
    wait_ads;
    @(posedge clk_in);
    bus_check_n_in <= 1'b0;
    @(posedge clk_in);
    bus_check_n_in <= 1'b1;
    wait_done;
    cyc(3);
    chk(exc_cnt, k + 1);
    chk(irq_out, 1'b1);
    apb(1'b0, bcc_pkg::OFS_MC_ADDR, 32'h0);
    chk(rd[31:3], 29'h333);
    apb(1'b0, bcc_pkg::OFS_MC_CTRL, 32'h0);
    chk(rd[5:0], 6'h1A);
    apb(1'b0, bcc_pkg::OFS_INT_STAT, 32'h0);
    apb(1'b0, bcc_pkg::OFS_INT_STAT, 32'h0);
    chk(rd[1], 1'b0);
  endtask

  // snoop bus check under stop clock, optionally a second snoop to the line
  task t_stop(input logic drop);
    int k;
    k = exc_cnt;
    @(posedge clk_in);
    stop_clock_request_n_in <= 1'b0;
    bus_check_n_in <= 1'b0;
    snoop_line_in <= 27'h0ABC;
    repeat (2) begin
      cyc(3);
      @(posedge clk_in);
      snoop_valid_in <= 1'b1;
      @(posedge clk_in);
      snoop_valid_in <= 1'b0;
      bus_check_n_in <= 1'b1;
      if (!drop) break;
    end
    cyc(6);
    chk(exc_cnt, k);
    @(posedge clk_in);
    stop_clock_request_n_in <= 1'b1;
    cyc(8);
    chk(exc_cnt, k + (drop ? 0 : 1));
    apb(1'b0, bcc_pkg::OFS_INT_STAT, 32'h0);
    chk(rd[3], drop);
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset;
    t_cycles;
    t_backoff;
    t_bp;
    t_bus_check_n;
    t_stop(1'b0);
    t_stop(1'b1);
    summarize;
  end

  // hang guard, far beyond the expected run
  initial begin
    #100000;
    n_errors++;
    summarize;
  end
endmodule // test_cpu_bus_cycle_control
